// *** logic/sxd_pkg.sv ***
package sxd_pkg;

  // Instruction classes presented by dispatch
  typedef enum logic [2:0] {
    SXD_CLS_PLAIN = 3'b000,
    SXD_CLS_SC = 3'b001,
    SXD_CLS_RFI = 3'b010,
    SXD_CLS_ISYNC = 3'b011,
    SXD_CLS_EXSYNC = 3'b100,
    SXD_CLS_BARRIER = 3'b101,
    SXD_CLS_TRAP = 3'b110,
    SXD_CLS_FP = 3'b111
  } sxd_cls_e;

  // Handler classes reported to vectoring
  typedef enum logic [3:0] {
    SXD_EXC_NONE = 4'h0,
    SXD_EXC_ISTOR = 4'h1,
    SXD_EXC_ILLEGAL = 4'h2,
    SXD_EXC_PRIV = 4'h3,
    SXD_EXC_TRAP = 4'h4,
    SXD_EXC_FPUNAVAIL = 4'h5,
    SXD_EXC_ALIGN = 4'h6,
    SXD_EXC_DSTOR = 4'h7,
    SXD_EXC_SYSCALL = 4'h8,
    SXD_EXC_FPENABLED = 4'h9
  } sxd_exc_e;

  // Sequencer states
  typedef enum logic [2:0] {
    SXD_ST_RUN = 3'b000,
    SXD_ST_DRAIN = 3'b001,
    SXD_ST_FLUSH = 3'b010,
    SXD_ST_EXC = 3'b011,
    SXD_ST_DONE = 3'b100
  } sxd_st_e;

  localparam int SXD_SPR_W = 10;
  localparam int SXD_ADDR_W = 64;
  localparam int SXD_NSPR = 4;
  // Special register numbers open to user mode
  localparam logic [SXD_SPR_W-1:0] SXD_SPR_USER0 = 10'h001;
  localparam logic [SXD_SPR_W-1:0] SXD_SPR_USER1 = 10'h008;
  localparam logic [SXD_SPR_W-1:0] SXD_SPR_USER2 = 10'h009;
  localparam logic [SXD_SPR_W-1:0] SXD_SPR_USER3 = 10'h10c;
  localparam logic [SXD_ADDR_W-1:0] SXD_INSN_STEP = 64'h0000000000000004;

endpackage

// *** logic/sxd_prio_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface sxd_prio_if;
  logic istor;
  logic illegal;
  logic priv;
  logic trap;
  logic fp_unavail;
  logic align;
  logic dstor;
  logic syscall;
  logic fp_enabled;
  sxd_pkg::sxd_exc_e winner;
  modport src (output istor, illegal, priv, trap, fp_unavail, align, dstor, syscall, fp_enabled,
               input winner);
  modport enc (input istor, illegal, priv, trap, fp_unavail, align, dstor, syscall, fp_enabled,
               output winner);
endinterface
`default_nettype wire

// *** logic/sxd_prio_enc.sv ***
`timescale 1ns/1ps
`default_nettype none
module sxd_prio_enc (
  // Raw conditions in, one winner out
  sxd_prio_if.enc p
);
  // Fixed order, fetch faults first since nothing else is known then
  always_comb begin
    if (p.istor) begin
      p.winner = sxd_pkg::SXD_EXC_ISTOR;
    end else if (p.illegal) begin
      p.winner = sxd_pkg::SXD_EXC_ILLEGAL;
    end else if (p.priv) begin
      p.winner = sxd_pkg::SXD_EXC_PRIV;
    end else if (p.fp_unavail) begin
      p.winner = sxd_pkg::SXD_EXC_FPUNAVAIL;
    end else if (p.syscall) begin
      p.winner = sxd_pkg::SXD_EXC_SYSCALL;
    end else if (p.trap) begin
      p.winner = sxd_pkg::SXD_EXC_TRAP;
    end else if (p.align) begin
      p.winner = sxd_pkg::SXD_EXC_ALIGN;
    end else if (p.dstor) begin
      p.winner = sxd_pkg::SXD_EXC_DSTOR;
    end else if (p.fp_enabled) begin
      p.winner = sxd_pkg::SXD_EXC_FPENABLED;
    end else begin
      p.winner = sxd_pkg::SXD_EXC_NONE;
    end
  end
endmodule // sxd_prio_enc
`default_nettype wire

// *** logic/sxd_top.sv ***
// Notes on behaviour
// [RL1] Context sync instructions drain, flush queue, refetch
// [RL2] Start only without higher exception; halt dispatch
// [RL3] Earlier instructions past exception point first
// [RL4] Earlier instructions finish in their issue context
// [RL5] Instruction sync refetches next sequential address
// [RL6] System call and return redirect like branches
// [RL7] Execution sync: conditions one, two only
// [RL8] Late context effective by next context sync
// [RL9] Illegal opcode raises illegal program exception
// [RL10] User supervisor instruction raises privileged exception
// [RL11] Special register privilege follows register number
// [RL12] Invalid form gives illegal or privileged
// [RL13] Absent optional instruction raises illegal
// [RL14] Protection or page fault: data/instruction storage
// [RL15] Bad alignment raises alignment exception
// [RL16] System call always raises system-call exception
// [RL17] Trap condition met raises trap exception
// [RL18] Floating point while disabled: unavailable exception
// [RL19] Enabled floating-point condition raises enabled exception
// [RL20] Only highest-priority condition is reported
`timescale 1ns/1ps
`default_nettype none
module sxd_top #(
  parameter int ADDR_W = sxd_pkg::SXD_ADDR_W,
  parameter int SPR_W = sxd_pkg::SXD_SPR_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Dispatch side
  input wire logic disp_valid,
  output logic disp_ready,
  input wire sxd_pkg::sxd_cls_e disp_cls,
  input wire logic [ADDR_W-1:0] disp_addr,
  input wire logic [ADDR_W-1:0] disp_target,
  input wire logic disp_supervisor_only,
  input wire logic disp_is_spr_move,
  input wire logic [SPR_W-1:0] disp_special_purpose_register,
  input wire logic disp_illegal,
  input wire logic disp_invalid_form,
  input wire logic disp_invalid_form_priv,
  input wire logic disp_optional_absent,
  input wire logic disp_trap_taken,
  input wire logic disp_fetch_fault,
  input wire logic disp_align_fault,
  input wire logic disp_data_fault,
  input wire logic disp_fp_cond_enabled,
  // Machine context
  input wire logic ctx_problem_state,
  input wire logic ctx_fp_enabled,
  input wire logic ctx_pending_update,
  output logic ctx_apply,
  // Completion side
  input wire logic cmp_empty,
  input wire logic cmp_exc_pending,
  input wire logic cmp_past_exc_point,
  // Fetch side
  output logic fetch_flush,
  output logic [ADDR_W-1:0] fetch_redirect_addr,
  // Handler vectoring
  output logic exc_valid,
  output sxd_pkg::sxd_exc_e exc_class,
  output logic [ADDR_W-1:0] exc_addr,
  input wire logic exc_ack
);

  sxd_pkg::sxd_st_e st_q;
  sxd_pkg::sxd_st_e st_d;
  sxd_pkg::sxd_cls_e cls_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] target_q;
  logic spr_user_ok;
  logic take;
  logic is_ctx_sync;
  logic is_sync;
  logic drained;
  logic [sxd_pkg::SXD_NSPR-1:0] spr_hit;
  logic [SPR_W-1:0] spr_tab [sxd_pkg::SXD_NSPR];

  sxd_prio_if pif ();

  assign spr_tab[0] = sxd_pkg::SXD_SPR_USER0;
  assign spr_tab[1] = sxd_pkg::SXD_SPR_USER1;
  assign spr_tab[2] = sxd_pkg::SXD_SPR_USER2;
  assign spr_tab[3] = sxd_pkg::SXD_SPR_USER3;

  // User access to a special register depends on its number
  for (genvar i = 0; i < sxd_pkg::SXD_NSPR; i++) begin : g_spr
    assign spr_hit[i] = (disp_special_purpose_register == spr_tab[i]); // see [RL11]
  end
  assign spr_user_ok = |spr_hit;

  // Raw conditions of the dispatching instruction
  assign pif.istor = disp_fetch_fault; // see [RL14]
  // A privileged invalid form is only privileged for user code
  assign pif.illegal = disp_illegal | disp_optional_absent // see [RL9] [RL13]
                     | (disp_invalid_form
                        & ~(disp_invalid_form_priv & ctx_problem_state)); // see [RL12]
  assign pif.priv = ctx_problem_state
                  & ((disp_supervisor_only & ~disp_is_spr_move)
                     | (disp_is_spr_move & ~spr_user_ok)
                     | (disp_invalid_form & disp_invalid_form_priv)); // see [RL10] [RL11] [RL12]
  assign pif.fp_unavail = (disp_cls == sxd_pkg::SXD_CLS_FP) & ~ctx_fp_enabled; // see [RL18]
  assign pif.syscall = (disp_cls == sxd_pkg::SXD_CLS_SC); // see [RL16]
  assign pif.trap = (disp_cls == sxd_pkg::SXD_CLS_TRAP) & disp_trap_taken; // see [RL17]
  assign pif.align = disp_align_fault; // see [RL15]
  assign pif.dstor = disp_data_fault; // see [RL14]
  assign pif.fp_enabled = (disp_cls == sxd_pkg::SXD_CLS_FP) & ctx_fp_enabled
                        & disp_fp_cond_enabled; // see [RL19]

  sxd_prio_enc u_prio (
    .p(pif.enc) // see [RL20]
  );

  assign is_ctx_sync = (disp_cls == sxd_pkg::SXD_CLS_SC) | (disp_cls == sxd_pkg::SXD_CLS_RFI)
                     | (disp_cls == sxd_pkg::SXD_CLS_ISYNC);
  assign is_sync = is_ctx_sync | (disp_cls == sxd_pkg::SXD_CLS_EXSYNC)
                 | (disp_cls == sxd_pkg::SXD_CLS_BARRIER);

  // Earlier work must be beyond faulting before a sync moves on
  assign drained = cmp_empty | (cmp_past_exc_point & ~cmp_exc_pending); // see [RL3] [RL7]

  // Dispatch halts whenever the sequencer is not idle
  assign disp_ready = (st_q == sxd_pkg::SXD_ST_RUN); // see [RL2]
  assign take = disp_valid & disp_ready;

  always_comb begin
    st_d = st_q;
    case (st_q)
      sxd_pkg::SXD_ST_RUN: begin
        if (take && pif.winner != sxd_pkg::SXD_EXC_NONE) begin
          st_d = sxd_pkg::SXD_ST_DRAIN;
        end else if (take && is_sync) begin
          st_d = sxd_pkg::SXD_ST_DRAIN; // see [RL1] [RL7]
        end
      end
      sxd_pkg::SXD_ST_DRAIN: begin
        // An older pending exception wins; this one waits behind it
        if (drained) begin // see [RL2] [RL3]
          if (exc_valid) begin
            st_d = sxd_pkg::SXD_ST_EXC;
          end else if (cls_q == sxd_pkg::SXD_CLS_RFI || cls_q == sxd_pkg::SXD_CLS_ISYNC) begin
            st_d = sxd_pkg::SXD_ST_FLUSH;
          end else begin
            st_d = sxd_pkg::SXD_ST_DONE;
          end
        end
      end
      sxd_pkg::SXD_ST_EXC: begin
        if (exc_ack) begin
          st_d = sxd_pkg::SXD_ST_FLUSH;
        end
      end
      sxd_pkg::SXD_ST_FLUSH: begin
        st_d = sxd_pkg::SXD_ST_RUN;
      end
      sxd_pkg::SXD_ST_DONE: begin
        st_d = sxd_pkg::SXD_ST_RUN;
      end
      default: begin
        st_d = sxd_pkg::SXD_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= sxd_pkg::SXD_ST_RUN;
    end else begin
      st_q <= st_d;
    end
  end

  // Capture the instruction being synchronised or faulted
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cls_q <= sxd_pkg::SXD_CLS_PLAIN;
      addr_q <= '0;
      target_q <= '0;
    end else if (take) begin
      cls_q <= disp_cls;
      addr_q <= disp_addr;
      target_q <= disp_target;
    end
  end

  // Reported exception held until vectoring accepts it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      exc_valid <= 1'b0;
      exc_class <= sxd_pkg::SXD_EXC_NONE;
      exc_addr <= '0;
    end else if (take && pif.winner != sxd_pkg::SXD_EXC_NONE) begin
      exc_valid <= 1'b1; // see [RL20]
      exc_class <= pif.winner;
      exc_addr <= disp_addr;
    end else if (st_q == sxd_pkg::SXD_ST_EXC && exc_ack) begin
      exc_valid <= 1'b0;
    end
  end

  // Flush and redirect; vectoring owns the handler address after a fault
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fetch_flush <= 1'b0;
      fetch_redirect_addr <= '0;
    end else begin
      fetch_flush <= (st_d == sxd_pkg::SXD_ST_FLUSH); // see [RL1]
      if (st_d == sxd_pkg::SXD_ST_FLUSH) begin
        if (cls_q == sxd_pkg::SXD_CLS_ISYNC && !exc_valid) begin
          fetch_redirect_addr <= ADDR_W'(addr_q + sxd_pkg::SXD_INSN_STEP); // see [RL5]
        end else begin
          fetch_redirect_addr <= target_q; // see [RL6]
        end
      end
    end
  end

  // New context is released only after older work drained, so earlier
  // instructions never see it; execution sync may defer it to the next
  // context sync, trading latency for a simpler pipeline
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctx_apply <= 1'b0;
    end else begin
      ctx_apply <= ctx_pending_update
                 & (st_d == sxd_pkg::SXD_ST_FLUSH); // see [RL4] [RL8]
    end
  end

endmodule // sxd_top
`default_nettype wire

// *** dv/sxd_top_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module sxd_top_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Observed ports
  input wire logic disp_valid,
  input wire logic disp_ready,
  input wire sxd_pkg::sxd_cls_e disp_cls,
  input wire logic disp_illegal,
  input wire logic disp_fetch_fault,
  input wire logic cmp_empty,
  input wire logic cmp_exc_pending,
  input wire logic cmp_past_exc_point,
  input wire logic fetch_flush,
  input wire logic ctx_apply,
  input wire logic exc_valid,
  input wire sxd_pkg::sxd_exc_e exc_class,
  input wire logic exc_ack
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic tk, dr, xs;
  assign tk = disp_valid && disp_ready;
  assign dr = cmp_empty || (cmp_past_exc_point && !cmp_exc_pending);
  assign xs = disp_cls inside {sxd_pkg::SXD_CLS_EXSYNC, sxd_pkg::SXD_CLS_BARRIER};
  property p_halt; tk && disp_cls inside {[3'h1:3'h5]} |=> !disp_ready; endproperty
  a_halt: assert property (p_halt) else $error("dispatch not halted");
  property p_sc; tk && disp_cls == sxd_pkg::SXD_CLS_SC |=> exc_valid; endproperty
  a_sc: assert property (p_sc) else $error("no syscall");
  property p_istor; tk && disp_fetch_fault |=> exc_class == sxd_pkg::SXD_EXC_ISTOR; endproperty
  a_istor: assert property (p_istor) else $error("fetch fault class");
  property p_ill; tk && disp_illegal && !disp_fetch_fault |=> exc_class == sxd_pkg::SXD_EXC_ILLEGAL;
  endproperty
  a_ill: assert property (p_ill) else $error("illegal class");
  property p_hold; exc_valid && !exc_ack |=> exc_valid && $stable(exc_class); endproperty
  a_hold: assert property (p_hold) else $error("report dropped");
  property p_vec; $fell(exc_valid) |-> fetch_flush; endproperty
  a_vec: assert property (p_vec) else $error("no redirect");
  // Fault path flushes after the ack, not after draining
  property p_drain; fetch_flush && !$past(exc_valid) |-> $past(dr); endproperty
  a_drain: assert property (p_drain) else $error("flush before drain");
  property p_pulse; fetch_flush |=> !fetch_flush && disp_ready; endproperty
  a_pulse: assert property (p_pulse) else $error("flush pulse");
  property p_ctx; ctx_apply |-> fetch_flush; endproperty
  a_ctx: assert property (p_ctx) else $error("context outside sync");
  property p_xs; tk && xs |=> !fetch_flush [*2]; endproperty
  a_xs: assert property (p_xs) else $error("exec sync flushed");
  c_ctx: cover property (fetch_flush && ctx_apply);
  c_xs: cover property (tk && xs);
  c_exc: cover property ($fell(exc_valid));
endmodule // sxd_top_props
bind sxd_top sxd_top_props u_sxd_top_props (.mclk, .rst, .disp_valid, .disp_ready, .disp_cls,
  .disp_illegal, .disp_fetch_fault, .cmp_empty, .cmp_exc_pending, .cmp_past_exc_point,
  .fetch_flush, .ctx_apply, .exc_valid, .exc_class, .exc_ack);
`default_nettype wire

// *** dv/sxd_cmp_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sxd_cmp_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Take and drain length
  input wire logic take,
  input wire logic [2:0] lat,
  // Completion view
  output logic cmp_empty,
  output logic cmp_exc_pending,
  output logic cmp_past_exc_point
);
  // Older work still in flight; may fault until its last cycle
  logic [2:0] cnt_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= 3'h0;
    end else if (take) begin
      cnt_q <= lat;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end
  assign cmp_empty = cnt_q == 3'h0;
  assign cmp_exc_pending = cnt_q > 3'h1;
  assign cmp_past_exc_point = cnt_q < 3'h2;
endmodule // sxd_cmp_model
`default_nettype wire

// *** dv/tb_sxd_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_sxd_top;
  logic mclk = 1'b0, rst = 1'b1, disp_valid = 1'b0, exc_ack = 1'b0, pend = 1'b0;
  logic user = 1'b0, fpen = 1'b1, seen = 1'b0, rdy, emp, pnd, pst, fl, app, ev;
  logic [2:0] cls = 3'h0, lat = 3'h0;
  logic [9:0] special_purpose_register = 10'h000;
  logic [10:0] f = 11'h000;
  logic [63:0] addr = 64'h0, tgt = 64'h0, fra, ea;
  sxd_pkg::sxd_exc_e ec;
  int n_mismatch = 0, n_checks = 0, seed = 49, i;
  logic [67:0] q_ex[$];
  logic [64:0] q_fl[$];
  always #10 mclk = ~mclk;
  sxd_cmp_model u_sxd_cmp_model (.mclk(mclk), .rst(rst), .take(disp_valid & rdy), .lat(lat),
    .cmp_empty(emp), .cmp_exc_pending(pnd), .cmp_past_exc_point(pst));
  sxd_top u_sxd_top (.mclk(mclk), .rst(rst), .disp_valid(disp_valid), .disp_ready(rdy),
    .disp_cls(sxd_pkg::sxd_cls_e'(cls)), .disp_addr(addr), .disp_target(tgt),
    .disp_supervisor_only(f[10]), .disp_is_spr_move(f[9]), .disp_special_purpose_register(special_purpose_register),
    .disp_illegal(f[8]), .disp_invalid_form(f[7]), .disp_invalid_form_priv(f[6]),
    .disp_optional_absent(f[5]), .disp_trap_taken(f[4]), .disp_fetch_fault(f[3]),
    .disp_align_fault(f[2]), .disp_data_fault(f[1]), .disp_fp_cond_enabled(f[0]),
    .ctx_problem_state(user), .ctx_fp_enabled(fpen), .ctx_pending_update(pend),
    .ctx_apply(app), .cmp_empty(emp), .cmp_exc_pending(pnd), .cmp_past_exc_point(pst),
    .fetch_flush(fl), .fetch_redirect_addr(fra), .exc_valid(ev), .exc_class(ec),
    .exc_addr(ea), .exc_ack(exc_ack));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk_exc(logic [67:0] e, logic [67:0] g);
    n_checks++;
    if (e !== g) begin
      n_mismatch++;
      $display("[ERR] exception exp %h got %h", e, g);
    end
  endtask
  task automatic chk_fl(logic [64:0] e, logic [64:0] g);
    n_checks++;
    if (e !== g) begin
      n_mismatch++;
      $display("[ERR] redirect exp %h got %h", e, g);
    end
  endtask
  // Fixed encoder order: first match wins
  function automatic logic [3:0] exp_exc(logic [2:0] c, logic [10:0] v, logic u, logic fe);
    logic ok;
    ok = special_purpose_register inside {sxd_pkg::SXD_SPR_USER0, sxd_pkg::SXD_SPR_USER1, sxd_pkg::SXD_SPR_USER2,
      sxd_pkg::SXD_SPR_USER3};
    if (v[3]) return sxd_pkg::SXD_EXC_ISTOR;
    if (v[8] | v[5] | (v[7] & !(v[6] & u))) begin
      return sxd_pkg::SXD_EXC_ILLEGAL;
    end
    // A register move is judged by its number alone
    if (u & ((v[10] & !v[9]) | (v[9] & !ok) | (v[7] & v[6]))) begin
      return sxd_pkg::SXD_EXC_PRIV;
    end
    if (c == 3'h7 && !fe) return sxd_pkg::SXD_EXC_FPUNAVAIL;
    if (c == 3'h1) return sxd_pkg::SXD_EXC_SYSCALL;
    if (v[4]) return sxd_pkg::SXD_EXC_TRAP;
    if (v[2]) return sxd_pkg::SXD_EXC_ALIGN;
    if (v[1]) return sxd_pkg::SXD_EXC_DSTOR;
    if (v[0]) return sxd_pkg::SXD_EXC_FPENABLED;
    return sxd_pkg::SXD_EXC_NONE;
  endfunction
  task automatic issue(logic [2:0] c, logic [10:0] v, logic u, logic fe, logic [9:0] s);
    logic [3:0] e;
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 60) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (rdy !== 1'b1) begin
      n_mismatch++;
      print_verdict();
    end
    // Trap and enabled-fp conditions only from their own classes
    v[4] = v[4] & (c == 3'h6);
    v[0] = v[0] & (c == 3'h7) & fe;
    cls = c;
    f = v;
    user = u & (c != 3'h2);
    fpen = fe;
    special_purpose_register = s;
    pend = 1'($random(seed));
    lat = 3'($random(seed));
    addr = {$random(seed), $random(seed)} & ~64'h3;
    tgt = {$random(seed), $random(seed)} & ~64'h3;
    e = exp_exc(c, f, user, fe);
    if (e != 4'h0) q_ex.push_back({e, addr});
    if (e != 4'h0 || c == 3'h2) q_fl.push_back({pend, tgt});
    else if (c == 3'h3) q_fl.push_back({pend, addr + sxd_pkg::SXD_INSN_STEP});
    disp_valid = 1'b1;
    @(posedge mclk);
    #1;
    // Idle edge so valid is never lowered and raised in one step
    disp_valid = 1'b0;
    @(posedge mclk);
    #1;
  endtask
  always @(posedge mclk) #1 exc_ack = 1'($random(seed));
  always @(negedge mclk) begin
    if (ev === 1'b1 && !seen) begin
      chk_exc(q_ex.size() ? q_ex.pop_front() : {68{1'bx}}, {ec, ea});
    end
    seen = ev === 1'b1;
    if (fl === 1'b1) begin
      chk_fl(q_fl.size() ? q_fl.pop_front() : {65{1'bx}}, {app, fra});
    end
  end
  initial begin
    repeat (5) @(posedge mclk);
    #1 rst = 1'b0;
    for (i = 0; i < 8; i++) issue(3'(i), 11'h000, 1'b0, 1'b1, 10'h000);
    issue(3'h7, 11'h000, 1'b0, 1'b0, 10'h000);
    issue(3'h6, 11'h010, 1'b1, 1'b1, 10'h000);
    issue(3'h0, 11'h400, 1'b1, 1'b1, 10'h000);
    issue(3'h0, 11'h200, 1'b1, 1'b1, 10'h100);
    issue(3'h0, 11'h200, 1'b1, 1'b1, sxd_pkg::SXD_SPR_USER1);
    issue(3'h0, 11'h600, 1'b1, 1'b1, sxd_pkg::SXD_SPR_USER1);
    issue(3'h0, 11'h0c0, 1'b1, 1'b1, 10'h000);
    issue(3'h0, 11'h0c0, 1'b0, 1'b1, 10'h000);
    issue(3'h0, 11'h020, 1'b0, 1'b1, 10'h000);
    issue(3'h7, 11'h001, 1'b0, 1'b1, 10'h000);
    issue(3'h1, 11'h006, 1'b1, 1'b1, 10'h000);
    issue(3'h3, 11'h7ff, 1'b1, 1'b0, 10'h000);
    for (i = 0; i < 60; i++) issue(3'($random(seed)), 11'($random(seed) & 32'h0000061f),
      1'($random(seed)), 1'($random(seed)), i[0] ? 10'h100 : sxd_pkg::SXD_SPR_USER3);
    repeat (40) @(posedge mclk);
    chk_fl(65'h0, 65'(q_ex.size() + q_fl.size()));
    print_verdict();
  end
endmodule // tb_sxd_top
`default_nettype wire
